// >>> design/jac_pkg.sv
`default_nettype none
package jac_pkg;
  // register map, 7-bit addresses
  localparam logic [6:0] JAC_ADDR_CH0 = 7'h07;
  localparam logic [6:0] JAC_ADDR_CH1 = 7'h0F;
  localparam logic [6:0] JAC_ADDR_CH2 = 7'h17;
  // field positions
  localparam int JAC_BIT_DEPTH_LO  = 0;
  localparam int JAC_BIT_ON_TX     = 1;
  localparam int JAC_BIT_DEPTH_HI  = 2;
  localparam int JAC_BIT_FLUSH     = 3;
  localparam int JAC_BIT_FAST_OFF  = 4;
  localparam int JAC_CTRL_W        = 5;
  // reset value of the writable field
  localparam logic [4:0] JAC_CTRL_RST = 5'h03;
  // serial frame: one direction bit, 7 address bits, 8 data bits
  localparam logic [4:0] JAC_HDR_LAST  = 5'h07;
  localparam logic [4:0] JAC_FRAME_LAST = 5'h0F;
  typedef enum logic [1:0] {
    JAC_IDLE = 2'b00,
    JAC_HDR  = 2'b01,
    JAC_DATA = 2'b11
  } jac_state_t;
endpackage
`default_nettype wire

// >>> design/jac_chan.sv
`timescale 1ns/10ps
`default_nettype none
// one channel's attenuator control register
module jac_chan #(
  parameter logic [6:0] CH_ADDR = 7'h07
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  // write strobe from the serial engine
  input  wire logic       wr_stb_i,
  input  wire logic [6:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       host_mode_i,
  // register contents
  output logic [4:0]      ctrl_o,
  output logic [7:0]      rdata_o,
  output logic            hit_o
);
  logic [4:0] ctrl_reg;
  logic       hit;

  assign hit     = (addr_i == CH_ADDR);
  assign hit_o   = hit;
  assign ctrl_o  = ctrl_reg;
  assign rdata_o = {3'h0, ctrl_reg};

  // writes land only under host control; pins own the part otherwise
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_reg <= jac_pkg::JAC_CTRL_RST;
    end else if (!host_mode_i) begin
      ctrl_reg[jac_pkg::JAC_BIT_FAST_OFF] <= 1'b0;
    end else if (wr_stb_i && hit) begin
      ctrl_reg <= wdata_i[4:0];
    end
  end

  // hardware mode never keeps the fast-recovery disable set
  hw_keeps_fast_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !host_mode_i |=> !ctrl_reg[jac_pkg::JAC_BIT_FAST_OFF])
    else $error("fast recovery disabled in hardware mode");

  // a host write to this address stores the low five bits
  host_write_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (wr_stb_i && hit && host_mode_i) |=> ctrl_reg == $past(wdata_i[4:0]))
    else $error("host write not stored");

  // other addresses leave this register alone
  addr_decode_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (host_mode_i && !(wr_stb_i && hit)) |=> $stable(ctrl_reg))
    else $error("register changed without its own write");

  // upper bits read zero
  upper_zero_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    rdata_o[7:5] == 3'h0)
    else $error("unused bits not zero");
endmodule // jac_chan
`default_nettype wire

// >>> design/jac_regs.sv
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - recovery disable at 0 keeps fast-recovery mode
// - disable write honoured only under host control
// - hardware mode: fast recovery always active
// - three channel registers at three addresses
module jac_regs (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  // mode strap: 1 host control, 0 hardware control
  input  wire logic       host_mode_i,
  // serial microprocessor port
  input  wire logic       cs_n_i,
  input  wire logic       sclk_i,
  input  wire logic       sdi_i,
  output logic            sdo_o,
  output logic            sdo_oe_o,
  // per-channel attenuator controls
  output logic [2:0]      fast_recovery_on_o,
  output logic [2:0]      attenuator_flush_o,
  output logic [2:0]      depth_select_hi_o,
  output logic [2:0]      depth_select_lo_o,
  output logic [2:0]      attenuator_on_transmit_o
);
  localparam logic [6:0] CH_ADDR [3] = '{jac_pkg::JAC_ADDR_CH0,
                                         jac_pkg::JAC_ADDR_CH1,
                                         jac_pkg::JAC_ADDR_CH2};

  logic              cs_n_meta, cs_n_sync;
  logic              sclk_meta, sclk_sync, sclk_prev;
  logic              sdi_meta, sdi_sync;
  logic              host_meta, host_sync;
  logic              sclk_rise, sclk_fall;
  jac_pkg::jac_state_t state_reg;
  logic [4:0]        cnt_reg;
  logic [7:0]        hdr_reg;
  logic [7:0]        data_reg;
  logic [7:0]        out_reg;
  logic              wr_stb;
  logic              hdr_done_reg;
  logic [7:0]        rdata;
  logic [4:0]        ctrl    [3];
  logic [7:0]        ch_rdata[3];
  logic [2:0]        ch_hit;

  // pins are asynchronous to clk_i: two flops before any use
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cs_n_meta <= 1'b1;
      cs_n_sync <= 1'b1;
      sclk_meta <= 1'b0;
      sclk_sync <= 1'b0;
      sclk_prev <= 1'b0;
      sdi_meta  <= 1'b0;
      sdi_sync  <= 1'b0;
      host_meta <= 1'b0;
      host_sync <= 1'b0;
    end else begin
      cs_n_meta <= cs_n_i;
      cs_n_sync <= cs_n_meta;
      sclk_meta <= sclk_i;
      sclk_sync <= sclk_meta;
      sclk_prev <= sclk_sync;
      sdi_meta  <= sdi_i;
      sdi_sync  <= sdi_meta;
      host_meta <= host_mode_i;
      host_sync <= host_meta;
    end
  end

  // edges seen only on the second stage, never the first
  assign sclk_rise = !cs_n_sync && sclk_sync && !sclk_prev;
  assign sclk_fall = !cs_n_sync && !sclk_sync && sclk_prev;

  // frame sequencer; deselect aborts a partial frame with no write
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= jac_pkg::JAC_IDLE;
      cnt_reg   <= 5'h00;
    end else if (cs_n_sync) begin
      state_reg <= jac_pkg::JAC_IDLE;
      cnt_reg   <= 5'h00;
    end else if (sclk_rise) begin
      cnt_reg <= cnt_reg + 5'h01;
      case (state_reg)
        jac_pkg::JAC_IDLE: state_reg <= jac_pkg::JAC_HDR;
        jac_pkg::JAC_HDR: begin
          if (cnt_reg == jac_pkg::JAC_HDR_LAST) begin
            state_reg <= jac_pkg::JAC_DATA;
          end
        end
        jac_pkg::JAC_DATA: begin
          if (cnt_reg == jac_pkg::JAC_FRAME_LAST) begin
            state_reg <= jac_pkg::JAC_IDLE;
          end
        end
        default: state_reg <= jac_pkg::JAC_IDLE;
      endcase
    end
  end

  // header and write data shift in lsb first
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hdr_reg  <= 8'h00;
      data_reg <= 8'h00;
    end else if (sclk_rise) begin
      if (state_reg == jac_pkg::JAC_DATA) begin
        data_reg <= {sdi_sync, data_reg[7:1]};
      end else begin
        hdr_reg <= {sdi_sync, hdr_reg[7:1]};
      end
    end
  end

  // one-cycle write strobe on the last bit of a write frame
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_stb <= 1'b0;
    end else begin
      wr_stb <= sclk_rise && (state_reg == jac_pkg::JAC_DATA) && !hdr_reg[0]
                && (cnt_reg == jac_pkg::JAC_FRAME_LAST) && host_sync;
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rdata = 8'h00;
    for (int i = 0; i < 3; i++) begin
      if (ch_hit[i]) begin
        rdata = ch_rdata[i];
      end
    end
  end

  // header end marked one cycle late: the last address bit lands on that
  // same edge, so decoding earlier would select the wrong register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hdr_done_reg <= 1'b0;
    end else begin
      hdr_done_reg <= sclk_rise && (state_reg == jac_pkg::JAC_HDR)
                      && (cnt_reg == jac_pkg::JAC_HDR_LAST);
    end
  end

  // read data loads once the header is complete, shifts on falling sclk
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_reg <= 8'h00;
    end else if (hdr_done_reg) begin
      out_reg <= rdata;
    end else if (sclk_fall && state_reg == jac_pkg::JAC_DATA) begin
      out_reg <= {1'b0, out_reg[7:1]};
    end
  end

  assign sdo_o    = out_reg[0];
  assign sdo_oe_o = !cs_n_sync && (state_reg == jac_pkg::JAC_DATA) && hdr_reg[0];

  // three identical channel registers
  for (genvar g = 0; g < 3; g++) begin : g_ch
    jac_chan #(
      .CH_ADDR (CH_ADDR[g])
    ) u_chan (
      .clk_i       (clk_i),
      .arst_n_i    (arst_n_i),
      .wr_stb_i    (wr_stb),
      .addr_i      (hdr_reg[7:1]),
      .wdata_i     (data_reg),
      .host_mode_i (host_sync),
      .ctrl_o      (ctrl[g]),
      .rdata_o     (ch_rdata[g]),
      .hit_o       (ch_hit[g])
    );
  end

  // registered controls toward the attenuator datapath
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fast_recovery_on_o       <= 3'h7;
      attenuator_flush_o       <= 3'h0;
      depth_select_hi_o        <= 3'h0;
      depth_select_lo_o        <= 3'h7;
      attenuator_on_transmit_o <= 3'h7;
    end else begin
      for (int i = 0; i < 3; i++) begin
        // hardware mode overrides the stored bit as well
        fast_recovery_on_o[i] <= !ctrl[i][jac_pkg::JAC_BIT_FAST_OFF]
                                 || !host_sync;
        attenuator_flush_o[i]       <= ctrl[i][jac_pkg::JAC_BIT_FLUSH];
        // 32-bit depth is hi=1, lo=0, chosen by host software
        depth_select_hi_o[i]        <= ctrl[i][jac_pkg::JAC_BIT_DEPTH_HI];
        depth_select_lo_o[i]        <= ctrl[i][jac_pkg::JAC_BIT_DEPTH_LO];
        attenuator_on_transmit_o[i] <= ctrl[i][jac_pkg::JAC_BIT_ON_TX];
      end
    end
  end

  // header completion followed by data phase
  sequence hdr_done_s;
    sclk_rise && state_reg == jac_pkg::JAC_HDR && cnt_reg == jac_pkg::JAC_HDR_LAST;
  endsequence
  sequence in_data_s;
    state_reg == jac_pkg::JAC_DATA;
  endsequence

  hdr_to_data_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    hdr_done_s |=> in_data_s)
    else $error("header end did not enter data phase");

  // a clear disable bit yields fast-recovery mode one cycle on
  fast_mode_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (!ctrl[0][jac_pkg::JAC_BIT_FAST_OFF]) |=> fast_recovery_on_o[0])
    else $error("fast recovery mode not active");

  // hardware mode holds fast recovery on for every channel
  hw_mode_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !host_sync [*2] |=> fast_recovery_on_o == 3'h7)
    else $error("fast recovery off in hardware mode");

  // no write strobe without host control
  host_only_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    wr_stb |-> $past(host_sync))
    else $error("write issued outside host mode");

  // channel 1 high depth output follows its stored depth bit
  depth_follow_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    1'b1 |=> depth_select_hi_o[1] == $past(ctrl[1][jac_pkg::JAC_BIT_DEPTH_HI]))
    else $error("depth select not forwarded");
endmodule // jac_regs
`default_nettype wire

// >>> tb/tb_jac_regs.sv
`timescale 1ns/10ps
`default_nettype none
module tb_jac_regs;
  // clock, reset and serial port drive
  logic       clk_i       = 1'b0;
  logic       arst_n_i    = 1'b0;
  logic       host_mode_i = 1'b1;
  logic       cs_n_i      = 1'b1;
  logic       sclk_i      = 1'b0;
  logic       sdi_i       = 1'b0;
  logic       sdo_o;
  logic       sdo_oe_o;
  logic [2:0] fast_recovery_on_o;
  logic [2:0] attenuator_flush_o;
  logic [2:0] depth_select_hi_o;
  logic [2:0] depth_select_lo_o;
  logic [2:0] attenuator_on_transmit_o;
  int         errors          = 0;
  int         samples_checked = 0;
  logic [7:0] rd_q;
  logic [6:0] addr [3] = '{jac_pkg::JAC_ADDR_CH0, jac_pkg::JAC_ADDR_CH1, jac_pkg::JAC_ADDR_CH2};

  // 25 MHz system clock
  always #20 clk_i = ~clk_i;

  jac_regs jac_regs_i (
    .clk_i                    (clk_i),
    .arst_n_i                 (arst_n_i),
    .host_mode_i              (host_mode_i),
    .cs_n_i                   (cs_n_i),
    .sclk_i                   (sclk_i),
    .sdi_i                    (sdi_i),
    .sdo_o                    (sdo_o),
    .sdo_oe_o                 (sdo_oe_o),
    .fast_recovery_on_o       (fast_recovery_on_o),
    .attenuator_flush_o       (attenuator_flush_o),
    .depth_select_hi_o        (depth_select_hi_o),
    .depth_select_lo_o        (depth_select_lo_o),
    .attenuator_on_transmit_o (attenuator_on_transmit_o)
  );

  // single comparison point, four-state exact
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // inputs only move on falling clock edges
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // one serial frame, lsb first; stop below 16 aborts by deselecting early
  task automatic frame(input logic rd, input logic [6:0] a, input logic [7:0] d, input int stop);
    logic [15:0] w;
    w = {d, a, rd};
    cs_n_i = 1'b0;
    wait_clk(4);
    for (int i = 0; i < stop; i++) begin
      sdi_i  = w[i];
      sclk_i = 1'b0;
      wait_clk(6);
      sclk_i = 1'b1;
      wait_clk(6);
      // each phase is 6 clk so the synchronised shift has settled
      if (rd && i >= 7 && i < 15) begin
        rd_q[i-7] = sdo_o;
        if (i == 7) begin
          check("sdo_oe", {7'h00, sdo_oe_o}, 8'h01);
        end
      end
    end
    sclk_i = 1'b0;
    wait_clk(6);
    cs_n_i = 1'b1;
    wait_clk(6);
  endtask

  task automatic rd_chk(input string what, input logic [6:0] a, input logic [7:0] exp);
    frame(1'b1, a, 8'h00, 16);
    check(what, rd_q, exp);
  endtask

  // channel outputs against the register image
  task automatic outs(input int ch, input logic [4:0] v, input logic fast_on);
    check("chan outputs", {3'h0, fast_recovery_on_o[ch], attenuator_flush_o[ch],
          depth_select_hi_o[ch], attenuator_on_transmit_o[ch], depth_select_lo_o[ch]},
          {3'h0, fast_on, v[3:0]});
  endtask

  // main sequence
  initial begin
    wait_clk(16);
    arst_n_i = 1'b1;
    wait_clk(4);
    for (int ch = 0; ch < 3; ch++) begin
      rd_chk("reset value", addr[ch], 8'h03);
      outs(ch, 5'h03, 1'b1);
    end
    frame(1'b0, addr[0], 8'hFF, 16);
    rd_chk("ch0 upper bits", addr[0], 8'h1F);
    outs(0, 5'h1F, 1'b0);
    rd_chk("ch1 untouched", addr[1], 8'h03);
    for (int ch = 0; ch < 3; ch++) begin
      frame(1'b0, addr[ch], 8'h06, 16);
      rd_chk("depth 32 setting", addr[ch], 8'h06);
      outs(ch, 5'h06, 1'b1);
    end
    // unmapped address writes nothing and reads zero
    frame(1'b0, 7'h08, 8'h1F, 16);
    rd_chk("unmapped", 7'h08, 8'h00);
    rd_chk("ch0 after unmapped", addr[0], 8'h06);
    // deselect mid-frame must not commit
    frame(1'b0, addr[1], 8'h10, 12);
    rd_chk("ch1 after abort", addr[1], 8'h06);
    frame(1'b0, addr[2], 8'h16, 16);
    outs(2, 5'h16, 1'b0);
    // strap to hardware control: fast recovery back on, writes ignored
    host_mode_i = 1'b0;
    wait_clk(6);
    outs(2, 5'h06, 1'b1);
    frame(1'b0, addr[2], 8'h19, 16);
    outs(2, 5'h06, 1'b1);
    host_mode_i = 1'b1;
    wait_clk(6);
    frame(1'b0, addr[2], 8'h1A, 16);
    outs(2, 5'h1A, 1'b0);
    tally_and_finish;
  end

  // watchdog, roughly five times the expected run
  initial begin
    wait_clk(20000);
    errors++;
    tally_and_finish;
  end
endmodule // tb_jac_regs
`default_nettype wire
